// *** rtl/map_table.sv ***
// Shared constants and types of the map decoder
package map_pkg;
	localparam int ADDR_W         = 24;
	localparam int INDEX_W        = 10;
	localparam int MAP_ENTRIES    = 1024;
	localparam int IDX1K_LSB      = 10;
	localparam int IDX16K_LSB     = 14;
	localparam int ALIAS_LSB      = 20;
	localparam int GROUP_W        = 4;
	localparam logic GRAN_RESET   = 1'b0;
	localparam logic [INDEX_W-1:0] GROUP_MASK = 10'h3F0;

	// Memory classes, one-hot
	typedef enum logic [4:0] {
		CLASS_TARGET   = 5'h01,
		CLASS_GUARDED  = 5'h02,
		CLASS_FAST     = 5'h04,
		CLASS_BOARD    = 5'h08,
		CLASS_OPT_FAST = 5'h10
	} mem_class_t;

	localparam mem_class_t CLASS_RESET = CLASS_TARGET;
endpackage

// Block class table: one write port, two combinational read ports
module map_table
	import map_pkg::*;
#(
	parameter int DEPTH = map_pkg::MAP_ENTRIES,
	parameter int IW    = map_pkg::INDEX_W
)
(
	// Clock, reset, enable
	input  wire logic                 clk_in,
	input  wire logic                 reset_in,
	input  wire logic                 ce_in,
	// Write port
	input  wire logic                 wr_en_in,
	input  wire logic [IW-1:0]        wr_index_in,
	input  wire map_pkg::mem_class_t  wr_class_in,
	// Read ports
	input  wire logic [IW-1:0]        rd_a_index_in,
	output map_pkg::mem_class_t       rd_a_class_out,
	input  wire logic [IW-1:0]        rd_b_index_in,
	output map_pkg::mem_class_t       rd_b_class_out
);
	mem_class_t entry_ff [DEPTH];
	mem_class_t nxt_entry [DEPTH];

	// Next contents of the table
	always_comb
	begin
		nxt_entry = entry_ff;
		if (ce_in && wr_en_in)
			nxt_entry[wr_index_in] = wr_class_in;
	end

	// Table storage, cleared to the target class
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				entry_ff[i] <= CLASS_RESET;
		end
		else
			entry_ff <= nxt_entry;
	end

	// Lookups
	assign rd_a_class_out = entry_ff[rd_a_index_in];
	assign rd_b_class_out = entry_ff[rd_b_index_in];
endmodule

// *** rtl/map_decoder.sv ***
module map_decoder
	import map_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                        clk_in,
	input  wire logic                        reset_in,
	input  wire logic                        ce_in,
	// Granularity control
	input  wire logic                        gran_load_in,
	input  wire logic                        gran_16k_in,
	input  wire logic                        host_restart_in,
	output logic                             gran_16k_out,
	// Map entry write
	input  wire logic                        map_wr_en_in,
	input  wire logic [map_pkg::INDEX_W-1:0] map_wr_index_in,
	input  wire map_pkg::mem_class_t         map_wr_class_in,
	// Processor address side
	input  wire logic                        req_valid_in,
	input  wire logic [map_pkg::ADDR_W-1:0]  req_addr_in,
	// Mapped memory side
	output logic                             dec_valid_out,
	output logic [map_pkg::ADDR_W-1:0]       dec_addr_out,
	output logic [map_pkg::INDEX_W-1:0]      dec_index_out,
	output logic                             sel_target_out,
	output logic                             sel_guarded_out,
	output logic                             sel_fast_out,
	output logic                             sel_board_out,
	output logic                             sel_opt_fast_out
);
	import map_pkg::*;

	logic                gran_ff;
	logic                nxt_gran;
	logic [INDEX_W-1:0]  idx_1k;
	logic [INDEX_W-1:0]  idx_16k;
	logic [INDEX_W-1:0]  idx_a;
	logic [INDEX_W-1:0]  idx_b;
	mem_class_t          class_a;
	mem_class_t          class_b;
	mem_class_t          class_eff;
	logic [ADDR_W-1:0]   map_addr;
	logic [INDEX_W-1:0]  idx_eff;
	logic                above_1m;
	logic                valid_ff;
	logic                nxt_valid;
	logic [ADDR_W-1:0]   addr_ff;
	logic [ADDR_W-1:0]   nxt_addr;
	logic [INDEX_W-1:0]  index_ff;
	logic [INDEX_W-1:0]  nxt_index;
	mem_class_t          class_ff;
	mem_class_t          nxt_class;

	// Block number of an address at either granularity
	function automatic logic [INDEX_W-1:0] block_index(input logic [ADDR_W-1:0] a, input logic coarse);
		block_index = coarse ? a[ADDR_W-1:IDX16K_LSB] : a[ALIAS_LSB-1:IDX1K_LSB];
	endfunction

	// Granularity bit; only reset or an explicit load changes it, a host restart does not
	always_comb
	begin
		nxt_gran = gran_ff;
		if (ce_in && gran_load_in)
			nxt_gran = gran_16k_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			gran_ff <= GRAN_RESET;
		else
			gran_ff <= nxt_gran;
	end

	assign gran_16k_out = gran_ff;

	map_table u_table (
		.clk_in         (clk_in),
		.reset_in       (reset_in),
		.ce_in          (ce_in),
		.wr_en_in       (map_wr_en_in),
		.wr_index_in    (map_wr_index_in),
		.wr_class_in    (map_wr_class_in),
		.rd_a_index_in  (idx_a),
		.rd_a_class_out (class_a),
		.rd_b_index_in  (idx_b),
		.rd_b_class_out (class_b)
	);

	// Lookup indexes: port A the block itself, port B the first entry of its 16K group
	always_comb
	begin
		idx_1k   = block_index(req_addr_in, 1'b0);
		idx_16k  = block_index(req_addr_in, 1'b1);
		above_1m = |req_addr_in[ADDR_W-1:ALIAS_LSB];
		idx_a    = gran_ff ? idx_16k : idx_1k;
		idx_b    = idx_1k & GROUP_MASK;
	end

	// Class selection and outgoing address
	always_comb
	begin
		class_eff = class_a;
		idx_eff   = idx_a;
		map_addr  = req_addr_in;
		if (!gran_ff)
		begin
			if (class_b == CLASS_OPT_FAST)
			begin
				class_eff = CLASS_OPT_FAST;
				idx_eff   = idx_b;
			end
			if (class_eff != CLASS_TARGET)
				map_addr = {{GROUP_W{1'b0}}, req_addr_in[ALIAS_LSB-1:0]};
			else if (above_1m)
				class_eff = CLASS_TARGET;
		end
		// At 16K the full address is kept, so there is no wrap
	end

	// Output stage registers
	always_comb
	begin
		nxt_valid = valid_ff;
		nxt_addr  = addr_ff;
		nxt_index = index_ff;
		nxt_class = class_ff;
		if (ce_in)
		begin
			nxt_valid = req_valid_in;
			if (req_valid_in)
			begin
				nxt_addr  = map_addr;
				nxt_index = idx_eff;
				nxt_class = class_eff;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			valid_ff <= 1'b0;
			addr_ff  <= '0;
			index_ff <= '0;
			class_ff <= CLASS_RESET;
		end
		else
		begin
			valid_ff <= nxt_valid;
			addr_ff  <= nxt_addr;
			index_ff <= nxt_index;
			class_ff <= nxt_class;
		end
	end

	// Decoded outputs
	assign dec_valid_out    = valid_ff;
	assign dec_addr_out     = addr_ff;
	assign dec_index_out    = index_ff;
	assign sel_target_out   = valid_ff && class_ff == CLASS_TARGET;
	assign sel_guarded_out  = valid_ff && class_ff == CLASS_GUARDED;
	assign sel_fast_out     = valid_ff && class_ff == CLASS_FAST;
	assign sel_board_out    = valid_ff && class_ff == CLASS_BOARD;
	assign sel_opt_fast_out = valid_ff && class_ff == CLASS_OPT_FAST;

	// Checks
	a_index_coarse: assert property (@(posedge clk_in) disable iff (reset_in)
		ce_in && req_valid_in && gran_ff |=> dec_index_out == $past(req_addr_in[23:14]))
		else $error("coarse index wrong");
	a_index_fine: assert property (@(posedge clk_in) disable iff (reset_in)
		ce_in && req_valid_in && !gran_ff && class_b != CLASS_OPT_FAST
		|=> dec_index_out == $past(req_addr_in[19:10]))
		else $error("fine index wrong");
	a_full_addr_16k: assert property (@(posedge clk_in) disable iff (reset_in)
		ce_in && req_valid_in && gran_ff |=> dec_addr_out == $past(req_addr_in))
		else $error("wrap seen at 16K");
	a_alias_fine: assert property (@(posedge clk_in) disable iff (reset_in)
		dec_valid_out && !gran_ff && !sel_target_out |-> dec_addr_out[23:20] == 4'h0)
		else $error("upper bits not ignored");
	a_target_pass: assert property (@(posedge clk_in) disable iff (reset_in)
		ce_in && req_valid_in ##1 sel_target_out |-> dec_addr_out == $past(req_addr_in))
		else $error("target address altered");
	a_above_1m_target: assert property (@(posedge clk_in) disable iff (reset_in)
		ce_in && req_valid_in && !gran_ff && class_a == CLASS_TARGET && class_b != CLASS_OPT_FAST
		|=> sel_target_out)
		else $error("unmappable area not passed to target");
	a_opt_fast_group: assert property (@(posedge clk_in) disable iff (reset_in)
		ce_in && req_valid_in && !gran_ff && class_b == CLASS_OPT_FAST
		|=> sel_opt_fast_out && dec_index_out[3:0] == 4'h0)
		else $error("optional fast not in 16K blocks");
	a_gran_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		!(ce_in && gran_load_in) ##0 host_restart_in |=> $stable(gran_16k_out))
		else $error("granularity lost on restart");
	a_gran_load: assert property (@(posedge clk_in) disable iff (reset_in)
		ce_in && gran_load_in |=> gran_16k_out == $past(gran_16k_in))
		else $error("granularity not loaded");
	a_one_select: assert property (@(posedge clk_in) disable iff (reset_in)
		dec_valid_out |-> $onehot({sel_target_out, sel_guarded_out, sel_fast_out,
			sel_board_out, sel_opt_fast_out}))
		else $error("select not one-hot");

	c_fine_alias: cover property (@(posedge clk_in) disable iff (reset_in)
		!gran_ff && sel_fast_out);
	c_coarse_board: cover property (@(posedge clk_in) disable iff (reset_in)
		gran_ff && sel_board_out);
	c_opt_fast: cover property (@(posedge clk_in) disable iff (reset_in)
		!gran_ff && sel_opt_fast_out);
	c_restart: cover property (@(posedge clk_in) disable iff (reset_in)
		gran_ff && host_restart_in);
endmodule

// *** verification/addr_bus_model.sv ***
// Processor address bus: one request per call, held for exactly one edge
module addr_bus_model
	import map_pkg::*;
(
	// Clock
	input  wire logic                  clk_in,
	// Request side
	output logic                       req_valid_out,
	output logic [map_pkg::ADDR_W-1:0] req_addr_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial
	begin
		req_valid_out = 1'b0;
		req_addr_out = 24'h000000;
	end

	// Released bus shows the inverted address, not a stale one
	task automatic issue(input logic [ADDR_W-1:0] addr);
		@(posedge clk_in);
		#1;
		req_valid_out = 1'b1;
		req_addr_out = addr;
		@(posedge clk_in);
		#1;
		req_valid_out = 1'b0;
		req_addr_out = ~addr;
	endtask
endmodule

// *** verification/emulator_memory_map_decoder_tb_top.sv ***
// Self-checking bench of the map decoder
module emulator_memory_map_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import map_pkg::*;

	logic                ce_in;
	logic                clk_in, reset_in, gran_load_in, gran_16k_in, host_restart_in;
	logic                map_wr_en_in, req_valid_in, dec_valid_out, gran_16k_out;
	logic [INDEX_W-1:0]  map_wr_index_in, dec_index_out;
	mem_class_t          map_wr_class_in;
	logic [ADDR_W-1:0]   req_addr_in, dec_addr_out;
	logic [4:0]          sel;
	int                  fail_count, checks_done;

	map_decoder dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .gran_load_in(gran_load_in),
		.gran_16k_in(gran_16k_in), .host_restart_in(host_restart_in), .gran_16k_out(gran_16k_out),
		.map_wr_en_in(map_wr_en_in), .map_wr_index_in(map_wr_index_in), .map_wr_class_in(map_wr_class_in),
		.req_valid_in(req_valid_in), .req_addr_in(req_addr_in), .dec_valid_out(dec_valid_out),
		.dec_addr_out(dec_addr_out), .dec_index_out(dec_index_out), .sel_target_out(sel[0]),
		.sel_guarded_out(sel[1]), .sel_fast_out(sel[2]), .sel_board_out(sel[3]), .sel_opt_fast_out(sel[4]));
	addr_bus_model bus (.clk_in(clk_in), .req_valid_out(req_valid_in), .req_addr_out(req_addr_in));

	// Clock of 8 ns
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// Counts and verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Reset held for ten edges; the table returns to all target
	task automatic do_reset();
		reset_in = 1'b1;
		repeat (10) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input mem_class_t cls);
		@(posedge clk_in);
		#1;
		map_wr_en_in = 1'b1;
		map_wr_index_in = idx;
		map_wr_class_in = cls;
		@(posedge clk_in);
		#1;
		map_wr_en_in = 1'b0;
	endtask

	task automatic gran(input logic g);
		@(posedge clk_in);
		#1;
		gran_load_in = 1'b1;
		gran_16k_in = g;
		@(posedge clk_in);
		#1;
		gran_load_in = 1'b0;
	endtask

	// One request, judged at the edge that answers it
	task automatic look(input logic [23:0] a, input logic [23:0] ea, input logic [9:0] ei, input logic [4:0] es);
		bus.issue(a);
		chk("valid", 24'(dec_valid_out), 24'h000001);
		chk("addr", dec_addr_out, ea);
		chk("index", 24'(dec_index_out), 24'(ei));
		chk("select", 24'(sel), 24'(es));
		@(posedge clk_in);
		#1;
		chk("idle valid", 24'(dec_valid_out), 24'h000000);
		chk("idle select", 24'(sel), 24'h000000);
	endtask

	task automatic test_reset();
		chk("gran", 24'(gran_16k_out), 24'h000000);
		look(24'hF00400, 24'hF00400, 10'h001, 5'h01);
		$display("reset test done");
	endtask

	// Guarded, fast and board entries fold bits 23..20 away
	task automatic test_alias();
		mem_class_t cls[3] = '{CLASS_GUARDED, CLASS_FAST, CLASS_BOARD};
		for (int i = 0; i < 3; i++)
		begin
			wr(10'h048, cls[i]);
			look(24'hF12345, 24'h012345, 10'h048, 5'(cls[i]));
		end
		wr(10'h049, CLASS_TARGET);
		look(24'h312400, 24'h312400, 10'h049, 5'h01);
		wr(10'h040, CLASS_OPT_FAST);
		look(24'h811000, 24'h011000, 10'h040, 5'h10);
		$display("alias test done");
	endtask

	// Change granularity only with every entry target, then decode in 16K
	task automatic test_16k();
		do_reset();
		gran(1'b1);
		chk("gran", 24'(gran_16k_out), 24'h000001);
		wr(10'h148, CLASS_BOARD);
		look(24'h520000, 24'h520000, 10'h148, 5'h08);
		look(24'h120000, 24'h120000, 10'h048, 5'h01);
		wr(10'h005, CLASS_OPT_FAST);
		look(24'h017FFF, 24'h017FFF, 10'h005, 5'h10);
		$display("16k test done");
	endtask

	task automatic test_restart();
		@(posedge clk_in);
		#1;
		host_restart_in = 1'b1;
		@(posedge clk_in);
		#1;
		host_restart_in = 1'b0;
		chk("gran", 24'(gran_16k_out), 24'h000001);
		look(24'h520000, 24'h520000, 10'h148, 5'h08);
		$display("restart test done");
	endtask

	// Clock enable low: load, write and request are all ignored
	task automatic test_ce();
		@(posedge clk_in);
		#1;
		ce_in = 1'b0;
		gran(1'b0);
		wr(10'h148, CLASS_GUARDED);
		bus.issue(24'h520000);
		chk("frozen valid", 24'(dec_valid_out), 24'h000000);
		chk("frozen gran", 24'(gran_16k_out), 24'h000001);
		@(posedge clk_in);
		#1;
		ce_in = 1'b1;
		look(24'h520000, 24'h520000, 10'h148, 5'h08);
		$display("clock enable test done");
	endtask

	// Main sequence
	initial
	begin
		fail_count = 0;
		checks_done = 0;
		ce_in = 1'b1;
		gran_load_in = 1'b0;
		gran_16k_in = 1'b0;
		host_restart_in = 1'b0;
		map_wr_en_in = 1'b0;
		map_wr_index_in = 10'h000;
		map_wr_class_in = CLASS_TARGET;
		do_reset();
		test_reset();
		test_alias();
		test_16k();
		test_restart();
		test_ce();
		print_verdict();
	end

	// Watchdog: the tests need well under a thousand cycles
	initial
	begin
		#100000;
		fail_count++;
		print_verdict();
	end
endmodule
